// [crst_consts.vh]
// Constants for the CPU register, status and trap unit.
`ifndef CRST_CONSTS_VH
`define CRST_CONSTS_VH
`define CRST_DW 16
`define CRST_MSB 15
`define CRST_GPR_NUM 8
`define CRST_SP_IDX 3'h6
`define CRST_PC_IDX 3'h7
`define CRST_WORD_STEP 16'h0002
`define CRST_PC_RST 16'h0000
`define CRST_SP_RST 16'h0000
`define CRST_PSW_RST 16'h0000
`define CRST_PSW_C 0
`define CRST_PSW_V 1
`define CRST_PSW_Z 2
`define CRST_PSW_N 3
`define CRST_PSW_T 4
`define CRST_PSW_PRI_LO 5
`define CRST_PSW_PRI_HI 7
`define CRST_PSW_T_MASK 16'h0010
`define CRST_PSW_LB_MASK 16'h00FF
`define CRST_PSW_ALL_MASK 16'hFFFF
`define CRST_VAR_SMALL 0
`define CRST_VAR_MID 1
`define CRST_VAR_EXT 2
`define CRST_FIXED_LEVEL 3'h4
`define CRST_BASE_AW 16
`define CRST_EXT_AW 22
`define CRST_IO_LOW 22'h001FFF
`define CRST_VEC_TOP 22'h0000FE
`define CRST_TVEC 22'h00000C
`define CRST_VEC_PSW_OFS 22'h000002
`define CRST_CYC_RD 4'h1
`define CRST_CYC_RMW 4'h2
`define CRST_CYC_RDBW 4'h4
`define CRST_CYC_WR 4'h8
`define CRST_OP_MOV 3'h0
`define CRST_OP_ADD 3'h1
`define CRST_OP_SUB 3'h2
`define CRST_OP_ASL 3'h3
`define CRST_OP_ASR 3'h4
`define CRST_OP_AND 3'h5
`define CRST_OP_OR 3'h6
`define CRST_PAW 8
`define CRST_A_PSW 8'h00
`define CRST_A_SP 8'h04
`define CRST_A_PC 8'h08
`define CRST_A_STAT 8'h0C
`define CRST_A_CTRL 8'h10
`define CRST_ST_ODD 1
`define CRST_CTRL_IEN 0
`endif

// [crst_gpr_mem.v]
// Small register array holding the six plain general registers.
`timescale 1ns/100ps
module crst_gpr_mem #(
  parameter DW = 16,
  parameter DEPTH = 6,
  parameter AW = 3
) (
  input wire clk,
  input wire ce,
  input wire we,
  input wire [AW-1:0] waddr,
  input wire [DW-1:0] wdata,
  input wire [AW-1:0] raddr,
  output reg [DW-1:0] rdata
);
  reg [DW-1:0] mem [0:DEPTH-1];

  always @(posedge clk) begin
    if (ce) begin
      if (we && (waddr < DEPTH))
        mem[waddr] <= wdata;
      // Out-of-range index reads zero rather than garbage
      if (raddr < DEPTH)
        rdata <= mem[raddr];
      else
        rdata <= {DW{1'b0}};
    end
  end
endmodule

// [crst_core.v]
// CPU register file, status word, bus cycle issue and trap sequencer.
`timescale 1ns/100ps
`include "crst_consts.vh"
module crst_core #(
  parameter VARIANT = 2,
  parameter ADDRW = 22
) (
  input wire clk,
  input wire reset,
  input wire ce,
  input wire [7:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire regWe,
  input wire [2:0] regIdx,
  input wire [15:0] regData,
  input wire [2:0] rdIdx,
  output reg [15:0] rdData,
  input wire aluGo,
  input wire [2:0] aluOp,
  input wire [15:0] aluA,
  input wire [15:0] aluB,
  input wire aluWr,
  input wire [2:0] aluDst,
  input wire fetchGo,
  output reg fetchDone,
  output reg [15:0] instrWord,
  input wire instrDone,
  input wire rtiGo,
  input wire reqGo,
  input wire [3:0] reqKind,
  input wire reqByte,
  input wire [ADDRW-1:0] reqAddr,
  input wire [15:0] reqData,
  output reg reqDone,
  output reg reqErr,
  output reg [15:0] reqRdata,
  input wire intReq,
  input wire [2:0] intPri,
  input wire [7:0] intVec,
  output reg intAck,
  output reg busStart,
  output reg [3:0] busKind,
  output reg busByte,
  output reg [ADDRW-1:0] busAddr,
  output reg [15:0] busWdata,
  output reg busPeriph,
  output reg busVector,
  input wire busDone,
  input wire [15:0] busRdata,
  output reg [15:0] processor_status_word,
  output reg [15:0] pc,
  output reg [15:0] sp,
  output wire unitIdle
);
  localparam S_IDLE = 8'h01;
  localparam S_PSHPS = 8'h02;
  localparam S_PSHPC = 8'h04;
  localparam S_VECPC = 8'h08;
  localparam S_VECPS = 8'h10;
  localparam S_POPPC = 8'h20;
  localparam S_POPPS = 8'h40;
  localparam S_USER = 8'h80;

  localparam [ADDRW-1:0] SPAN = (VARIANT == `CRST_VAR_EXT) ?
    {ADDRW{1'b1}} :
    {{(ADDRW-`CRST_BASE_AW){1'b0}}, {`CRST_BASE_AW{1'b1}}};
  localparam [ADDRW-1:0] IOLOW = `CRST_IO_LOW;
  localparam [ADDRW-1:0] VTOP = `CRST_VEC_TOP;
  localparam [15:0] PSW_KEEP = (VARIANT == `CRST_VAR_EXT) ?
    `CRST_PSW_ALL_MASK : `CRST_PSW_LB_MASK;

  reg [7:0] state;
  reg issued;
  reg tPend;
  reg iPend;
  reg [7:0] iVec;
  reg [ADDRW-1:0] vecBase;
  reg [ADDRW-1:0] uAddr;
  reg [3:0] uKind;
  reg uByte;
  reg [15:0] uData;
  reg uFetch;
  reg oddSticky;
  reg intEnable;
  reg [2:0] rdIdxQ;
  wire [15:0] memQ;

  function [ADDRW-1:0] ext16;
    input [15:0] v;
    begin
      ext16 = {{(ADDRW-`CRST_DW){1'b0}}, v};
    end
  endfunction

  assign unitIdle = state[0];

  // Interrupt recognition
  wire [2:0] curPri = processor_status_word[`CRST_PSW_PRI_HI:`CRST_PSW_PRI_LO];
  wire [2:0] reqLvl = (VARIANT == `CRST_VAR_SMALL) ?
    `CRST_FIXED_LEVEL : intPri;
  // Four levels means only the upper half of the code space is honoured
  wire lvlOk = (VARIANT == `CRST_VAR_SMALL) ||
    intPri[2];
  wire intWin = intEnable && intReq && lvlOk &&
    (reqLvl > curPri);

  // Arithmetic unit
  wire [16:0] sum = {1'b0, aluA} + {1'b0, aluB};
  wire [16:0] diff = {1'b0, aluA} - {1'b0, aluB};
  reg [15:0] aluRes;
  reg aluC;
  reg aluV;
  always @* begin
    aluRes = aluA;
    aluC = processor_status_word[`CRST_PSW_C];
    aluV = 1'b0;
    case (aluOp)
      `CRST_OP_ADD: begin
        aluRes = sum[15:0];
        aluC = sum[16];
        aluV = (aluA[`CRST_MSB] == aluB[`CRST_MSB]) &&
          (sum[`CRST_MSB] != aluA[`CRST_MSB]);
      end
      `CRST_OP_SUB: begin
        aluRes = diff[15:0];
        aluC = diff[16];
        aluV = (aluA[`CRST_MSB] != aluB[`CRST_MSB]) &&
          (diff[`CRST_MSB] != aluA[`CRST_MSB]);
      end
      `CRST_OP_ASL: begin
        aluRes = {aluA[14:0], 1'b0};
        aluC = aluA[`CRST_MSB];
        aluV = aluA[14] ^ aluA[`CRST_MSB];
      end
      `CRST_OP_ASR: begin
        aluRes = {aluA[`CRST_MSB], aluA[15:1]};
        aluC = aluA[0];
        aluV = aluA[`CRST_MSB] ^ aluA[0];
      end
      `CRST_OP_AND: aluRes = aluA & aluB;
      `CRST_OP_OR: aluRes = aluA | aluB;
      default: aluRes = aluA;
    endcase
  end

  // Plain registers live in the array; stack and counter are flops
  wire aluMemWr = aluGo && aluWr && (aluDst < `CRST_SP_IDX);
  wire regMemWr = regWe && (regIdx < `CRST_SP_IDX);
  crst_gpr_mem #(
    .DW(`CRST_DW),
    .DEPTH(`CRST_GPR_NUM - 2),
    .AW(3)
  ) u_gpr (
    .clk(clk),
    .ce(ce),
    .we(aluMemWr || regMemWr),
    .waddr(aluMemWr ? aluDst : regIdx),
    .wdata(aluMemWr ? aluRes : regData),
    .raddr(rdIdx),
    .rdata(memQ)
  );

  // Bus request for the current sequencer state
  wire [15:0] spDown = sp - `CRST_WORD_STEP;
  wire [15:0] spInc = sp + `CRST_WORD_STEP;
  reg [ADDRW-1:0] stAddr;
  reg [3:0] stKind;
  reg stByte;
  reg [15:0] stData;
  always @* begin
    stAddr = uAddr;
    stKind = uKind;
    stByte = uByte;
    stData = uData;
    case (state)
      S_PSHPS: begin
        stAddr = ext16(spDown);
        stKind = `CRST_CYC_WR;
        stByte = 1'b0;
        stData = processor_status_word;
      end
      S_PSHPC: begin
        stAddr = ext16(spDown);
        stKind = `CRST_CYC_WR;
        stByte = 1'b0;
        stData = pc;
      end
      S_VECPC: begin
        stAddr = vecBase;
        stKind = `CRST_CYC_RD;
        stByte = 1'b0;
      end
      S_VECPS: begin
        stAddr = vecBase + `CRST_VEC_PSW_OFS;
        stKind = `CRST_CYC_RD;
        stByte = 1'b0;
      end
      S_POPPC, S_POPPS: begin
        stAddr = ext16(sp);
        stKind = `CRST_CYC_RD;
        stByte = 1'b0;
      end
      default: stByte = uByte;
    endcase
  end
  wire [ADDRW-1:0] stEff = stAddr & SPAN;
  wire [15:0] stLane = !stByte ? stData :
    (stEff[0] ? {stData[7:0], 8'h00} : {8'h00, stData[7:0]});

  // Word requests at odd addresses are refused; fetch and stack cycles are not checked
  wire reqIsByte = (reqKind == `CRST_CYC_RDBW) ||
    ((reqKind == `CRST_CYC_WR) && reqByte);
  wire reqOdd = reqAddr[0] && !reqIsByte;

  // Register bus read mux
  wire apbHit = (paddr == `CRST_A_PSW) || (paddr == `CRST_A_SP) ||
    (paddr == `CRST_A_PC) || (paddr == `CRST_A_STAT) ||
    (paddr == `CRST_A_CTRL);
  reg [31:0] apbMux;
  always @* begin
    apbMux = 32'h00000000;
    case (paddr)
      `CRST_A_PSW: apbMux = {16'h0000, processor_status_word};
      `CRST_A_SP: apbMux = {16'h0000, sp};
      `CRST_A_PC: apbMux = {16'h0000, pc};
      `CRST_A_STAT: apbMux = {28'h0000000, iPend, tPend, oddSticky,
        ~state[0]};
      `CRST_A_CTRL: apbMux = {31'h00000000, intEnable};
      default: apbMux = 32'h00000000;
    endcase
  end
  wire apbWr = psel && penable && pready && pwrite && apbHit;

  always @(posedge clk) begin
    if (reset) begin
      rdIdxQ <= 3'h0;
      rdData <= 16'h0000;
    end else if (ce) begin
      rdIdxQ <= rdIdx;
      if (rdIdxQ == `CRST_SP_IDX)
        rdData <= sp;
      else if (rdIdxQ == `CRST_PC_IDX)
        rdData <= pc;
      else
        rdData <= memQ;
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      state <= S_IDLE;
      issued <= 1'b0;
      tPend <= 1'b0;
      iPend <= 1'b0;
      iVec <= 8'h00;
      vecBase <= {ADDRW{1'b0}};
      uAddr <= {ADDRW{1'b0}};
      uKind <= `CRST_CYC_RD;
      uByte <= 1'b0;
      uData <= 16'h0000;
      uFetch <= 1'b0;
      oddSticky <= 1'b0;
      intEnable <= 1'b0;
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      fetchDone <= 1'b0;
      instrWord <= 16'h0000;
      reqDone <= 1'b0;
      reqErr <= 1'b0;
      reqRdata <= 16'h0000;
      intAck <= 1'b0;
      busStart <= 1'b0;
      busKind <= `CRST_CYC_RD;
      busByte <= 1'b0;
      busAddr <= {ADDRW{1'b0}};
      busWdata <= 16'h0000;
      busPeriph <= 1'b0;
      busVector <= 1'b0;
      processor_status_word <= `CRST_PSW_RST;
      pc <= `CRST_PC_RST;
      sp <= `CRST_SP_RST;
    end else if (ce) begin
      busStart <= 1'b0;
      fetchDone <= 1'b0;
      reqDone <= 1'b0;
      reqErr <= 1'b0;
      intAck <= 1'b0;
      // One wait state, then the write lands on the completing edge
      if (psel && penable && !pready) begin
        pready <= 1'b1;
        prdata <= apbMux;
        pslverr <= !apbHit;
      end else begin
        pready <= 1'b0;
        pslverr <= 1'b0;
      end
      if (apbWr && (paddr == `CRST_A_PSW))
        processor_status_word <= (pwdata[15:0] & PSW_KEEP & ~`CRST_PSW_T_MASK) |
          (processor_status_word & `CRST_PSW_T_MASK);
      if (apbWr && (paddr == `CRST_A_CTRL))
        intEnable <= pwdata[`CRST_CTRL_IEN];
      if (apbWr && (paddr == `CRST_A_STAT) && pwdata[`CRST_ST_ODD])
        oddSticky <= 1'b0;
      if (regWe && (regIdx == `CRST_SP_IDX))
        sp <= regData;
      if (regWe && (regIdx == `CRST_PC_IDX))
        pc <= regData;
      if (aluGo) begin
        processor_status_word[`CRST_PSW_C] <= aluC;
        processor_status_word[`CRST_PSW_V] <= aluV;
        processor_status_word[`CRST_PSW_Z] <= (aluRes == 16'h0000);
        processor_status_word[`CRST_PSW_N] <= aluRes[`CRST_MSB];
        if (aluWr && (aluDst == `CRST_SP_IDX))
          sp <= aluRes;
        if (aluWr && (aluDst == `CRST_PC_IDX))
          pc <= aluRes;
      end
      case (state)
        S_IDLE: begin
          if (tPend) begin
            tPend <= 1'b0;
            vecBase <= `CRST_TVEC;
            state <= S_PSHPS;
          end else if (iPend) begin
            iPend <= 1'b0;
            intAck <= 1'b1;
            // Even and never above the vector area
            vecBase <= ext16({8'h00, iVec[7:1], 1'b0});
            state <= S_PSHPS;
          end else if (rtiGo) begin
            state <= S_POPPC;
          end else if (reqGo) begin
            if (reqOdd) begin
              reqErr <= 1'b1;
              oddSticky <= 1'b1;
            end else begin
              uAddr <= reqAddr;
              uKind <= reqKind;
              uByte <= reqIsByte;
              uData <= reqData;
              uFetch <= 1'b0;
              state <= S_USER;
            end
          end else if (fetchGo) begin
            uAddr <= ext16(pc);
            uKind <= `CRST_CYC_RD;
            uByte <= 1'b0;
            uFetch <= 1'b1;
            state <= S_USER;
          end
        end
        S_PSHPS, S_PSHPC, S_VECPC, S_VECPS, S_POPPC, S_POPPS,
        S_USER: begin
          if (!issued) begin
            issued <= 1'b1;
            busStart <= 1'b1;
            busKind <= stKind;
            busByte <= stByte;
            busAddr <= stEff;
            busWdata <= stLane;
            busPeriph <= ((stEff | IOLOW) == SPAN);
            busVector <= (stEff <= VTOP);
            if ((state == S_PSHPS) || (state == S_PSHPC))
              sp <= spDown;
          end else if (busDone) begin
            issued <= 1'b0;
            case (state)
              S_PSHPS: state <= S_PSHPC;
              S_PSHPC: state <= S_VECPC;
              S_VECPC: begin
                pc <= busRdata;
                state <= S_VECPS;
              end
              S_VECPS: begin
                processor_status_word <= busRdata & PSW_KEEP;
                state <= S_IDLE;
              end
              S_POPPC: begin
                pc <= busRdata;
                sp <= spInc;
                state <= S_POPPS;
              end
              S_POPPS: begin
                processor_status_word <= busRdata & PSW_KEEP;
                sp <= spInc;
                state <= S_IDLE;
              end
              default: begin
                if (uFetch) begin
                  instrWord <= busRdata;
                  pc <= pc + `CRST_WORD_STEP;
                  fetchDone <= 1'b1;
                end else begin
                  reqRdata <= busRdata;
                  reqDone <= 1'b1;
                end
                state <= S_IDLE;
              end
            endcase
          end
        end
        default: state <= S_IDLE;
      endcase
      // Placed last so a new trace event beats the take in the same cycle; a new interrupt is not latched while iPend is set
      if (instrDone && processor_status_word[`CRST_PSW_T])
        tPend <= 1'b1;
      if (instrDone && intWin && !iPend) begin
        iPend <= 1'b1;
        iVec <= intVec;
      end
    end
  end
endmodule

// [crst_core_checker.sv]
// Assertion checker for the CPU register, status and trap unit.
`timescale 1ns/100ps
module crst_core_checker #(
  parameter ADDRW = 22
) (
  input wire clk,
  input wire reset,
  input wire aluGo,
  input wire [2:0] aluOp,
  input wire [15:0] aluA,
  input wire [15:0] aluB,
  input wire fetchDone,
  input wire instrDone,
  input wire reqGo,
  input wire [3:0] reqKind,
  input wire reqByte,
  input wire [ADDRW-1:0] reqAddr,
  input wire [15:0] reqData,
  input wire reqErr,
  input wire intReq,
  input wire busStart,
  input wire [3:0] busKind,
  input wire busByte,
  input wire [ADDRW-1:0] busAddr,
  input wire [15:0] busWdata,
  input wire busPeriph,
  input wire busVector,
  input wire [15:0] processor_status_word,
  input wire [15:0] pc,
  input wire unitIdle
);
  reg [3:0] addFlags;
  wire [16:0] sum = aluA + aluB;
  wire quiet = unitIdle && !processor_status_word[4] && !intReq;

  // Flags an ADD must leave, one edge behind the operands
  always @(posedge clk)
    addFlags <= {sum[15], sum[15:0] == 16'h0000,
      aluA[15] == aluB[15] && sum[15] != aluA[15], sum[16]};

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  odd_err_a: assert property (reqGo && quiet && reqAddr[0] &&
    reqKind != 4'h4 && (reqKind != 4'h8 || !reqByte)
    |=> reqErr ##1 !busStart [*2]) else $error("odd word not refused");
  word_even_a: assert property (busStart && busKind != 4'h4 &&
    !(busKind == 4'h8 && busByte) |-> !busAddr[0])
    else $error("word cycle at odd address");
  byte_lane_a: assert property (reqGo && quiet && reqKind == 4'h8 &&
    reqByte && reqAddr[0] |-> ##2 busStart && busKind == 4'h8 &&
    busWdata[15:8] == $past(reqData[7:0], 2)) else $error("byte lane");
  periph_map_a: assert property (busStart |->
    busPeriph == &busAddr[ADDRW-1:13]) else $error("peripheral flag");
  vector_zone_a: assert property (busStart |->
    busVector == (busAddr <= 22'h0000FE)) else $error("vector flag");
  tbit_trap_a: assert property (instrDone && processor_status_word[4] |->
    ##[4:80] busStart && busAddr == 22'h00000C)
    else $error("trap vector not read");
  add_flags_a: assert property (aluGo && aluOp == 3'h1 |=>
    processor_status_word[3:0] == addFlags) else $error("add flags wrong");
  fetch_step_a: assert property (fetchDone |->
    pc == $past(pc) + 16'h0002) else $error("counter not stepped");
endmodule

bind crst_core crst_core_checker #(.ADDRW(ADDRW)) u_crst_core_checker (
  .clk(clk), .reset(reset), .aluGo(aluGo), .aluOp(aluOp), .aluA(aluA),
  .aluB(aluB), .fetchDone(fetchDone), .instrDone(instrDone), .reqGo(reqGo),
  .reqKind(reqKind), .reqByte(reqByte), .reqAddr(reqAddr),
  .reqData(reqData), .reqErr(reqErr), .intReq(intReq), .busStart(busStart),
  .busKind(busKind), .busByte(busByte), .busAddr(busAddr),
  .busWdata(busWdata), .busPeriph(busPeriph), .busVector(busVector),
  .processor_status_word(processor_status_word), .pc(pc), .unitIdle(unitIdle));

// [crst_bus_model.sv]
// Memory model answering the unit's bus cycles.
`timescale 1ns/100ps
module crst_bus_model (
  input wire clk,
  input wire reset,
  input wire busStart,
  input wire [3:0] busKind,
  input wire busByte,
  input wire [21:0] busAddr,
  input wire [15:0] busWdata,
  output reg busDone,
  output reg [15:0] busRdata
);
  reg [15:0] mem [0:127];
  reg [7:0] j;
  reg [1:0] cnt;
  reg slow;
  reg pend;
  wire [6:0] w = busAddr[7:1];

  initial begin
    for (j = 8'h00; j < 8'h80; j = j + 8'h01)
      mem[j[6:0]] = 16'h0200 + {7'h00, j, 1'h0};
  end

  // Prompt and slow answers alternate; idle data is inverted each cycle
  always @(posedge clk) begin
    busDone <= 1'h0;
    busRdata <= ~busRdata;
    if (reset) begin
      pend <= 1'h0;
      slow <= 1'h0;
      busRdata <= 16'hA5A5;
    end else if (busStart) begin
      pend <= 1'h1;
      cnt <= {slow, slow};
      slow <= ~slow;
    end else if (pend && cnt != 2'h0) begin
      cnt <= cnt - 2'h1;
    end else if (pend) begin
      pend <= 1'h0;
      busDone <= 1'h1;
      busRdata <= mem[w];
      if (busKind == 4'h2 || (busKind == 4'h8 && !busByte))
        mem[w] <= busWdata;
      else if (busKind != 4'h1 && busAddr[0])
        mem[w][15:8] <= busWdata[15:8];
      else if (busKind != 4'h1)
        mem[w][7:0] <= busWdata[7:0];
    end
  end
endmodule

// [crst_core_test.sv]
// Self-checking bench for the CPU register, status and trap unit.
`timescale 1ns/100ps
module crst_core_test;
  reg clk, reset, ce, psel, penable, pwrite, regWe, aluGo, aluWr, fetchGo;
  reg instrDone, rtiGo, reqGo, reqByte, intReq, lastErr, seen;
  reg [7:0] paddr, intVec;
  reg [31:0] pwdata;
  reg [2:0] regIdx, rdIdx, aluOp, aluDst, intPri;
  reg [15:0] regData, aluA, aluB, reqData;
  reg [3:0] reqKind;
  reg [21:0] reqAddr;
  wire [31:0] prdata;
  wire pready, pslverr, fetchDone, reqDone, reqErr, intAck, busStart;
  wire busByte, busPeriph, busVector, busDone, unitIdle;
  wire [15:0] rdData, instrWord, reqRdata, busWdata, busRdata, processor_status_word, pc, sp;
  wire [3:0] busKind;
  wire [21:0] busAddr;
  integer nMismatch, nTests, k;

  crst_core #(.VARIANT(2), .ADDRW(22)) u_crst_core (.clk(clk), .reset(reset),
    .ce(ce), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .regWe(regWe), .regIdx(regIdx), .regData(regData), .rdIdx(rdIdx),
    .rdData(rdData), .aluGo(aluGo), .aluOp(aluOp), .aluA(aluA), .aluB(aluB),
    .aluWr(aluWr), .aluDst(aluDst), .fetchGo(fetchGo), .fetchDone(fetchDone),
    .instrWord(instrWord), .instrDone(instrDone), .rtiGo(rtiGo),
    .reqGo(reqGo), .reqKind(reqKind), .reqByte(reqByte), .reqAddr(reqAddr),
    .reqData(reqData), .reqDone(reqDone), .reqErr(reqErr),
    .reqRdata(reqRdata), .intReq(intReq), .intPri(intPri), .intVec(intVec),
    .intAck(intAck), .busStart(busStart), .busKind(busKind),
    .busByte(busByte), .busAddr(busAddr), .busWdata(busWdata),
    .busPeriph(busPeriph), .busVector(busVector), .busDone(busDone),
    .busRdata(busRdata), .processor_status_word(processor_status_word), .pc(pc), .sp(sp), .unitIdle(unitIdle));
  crst_bus_model u_crst_bus_model (.clk(clk), .reset(reset),
    .busStart(busStart), .busKind(busKind), .busByte(busByte),
    .busAddr(busAddr), .busWdata(busWdata), .busDone(busDone),
    .busRdata(busRdata));

  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end

  task chk(input [31:0] got, input [31:0] exp);
    begin
      nTests = nTests + 1;
      if (got !== exp) begin
        nMismatch = nMismatch + 1;
        $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask

  task wrapUp;
    begin
      $display("checks %0d mismatches %0d", nTests, nMismatch);
      if (nMismatch == 0 && nTests > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask

  function hit(input [2:0] w);
    case (w)
      3'h0: hit = pready;
      3'h1: hit = reqDone | reqErr;
      3'h2: hit = fetchDone;
      3'h3: hit = busStart;
      3'h4: hit = intAck;
      default: hit = unitIdle;
    endcase
  endfunction

  task waitOn(input [2:0] w);
    begin
      k = 0;
      @(posedge clk);
      while (hit(w) !== 1'h1) begin
        k = k + 1;
        if (k > 300) begin
          nMismatch = nMismatch + 1;
          $display("[ERR] %0t wait timed out", $time);
          wrapUp;
        end
        @(posedge clk);
      end
    end
  endtask

  task apb(input [7:0] a, input w, input [31:0] d);
    begin
      @(posedge clk);
      psel <= 1'h1;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'h1;
      waitOn(3'h0);
      if (!w)
        chk(prdata, d);
      lastErr = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
    end
  endtask

  task wreg(input [2:0] i, input [15:0] d);
    begin
      @(posedge clk);
      regIdx <= i;
      regData <= d;
      regWe <= 1'h1;
      @(posedge clk);
      regWe <= 1'h0;
    end
  endtask

  task alu(input [2:0] op, input [15:0] a, input [15:0] b, input [3:0] e);
    begin
      @(posedge clk);
      aluOp <= op;
      aluA <= a;
      aluB <= b;
      aluGo <= 1'h1;
      @(posedge clk);
      aluGo <= 1'h0;
      @(posedge clk);
      chk(processor_status_word[3:0], e);
    end
  endtask

  task pulse(input [1:0] w);
    begin
      @(posedge clk);
      case (w)
        2'h0: instrDone <= 1'h1;
        2'h1: rtiGo <= 1'h1;
        default: fetchGo <= 1'h1;
      endcase
      @(posedge clk);
      instrDone <= 1'h0;
      rtiGo <= 1'h0;
      fetchGo <= 1'h0;
    end
  endtask

  task req(input [3:0] kd, input b, input [21:0] a, input [15:0] d,
      input [15:0] e, input er);
    begin
      @(posedge clk);
      reqKind <= kd;
      reqByte <= b;
      reqAddr <= a;
      reqData <= d;
      reqGo <= 1'h1;
      @(posedge clk);
      reqGo <= 1'h0;
      waitOn(3'h1);
      chk(reqErr, er);
      if (kd != 4'h8 && !er)
        chk(reqRdata, e);
    end
  endtask

  // Twelve cycles watching for an interrupt acknowledge
  task noAck;
    begin
      seen = 1'h0;
      repeat (12) begin
        @(posedge clk);
        seen = seen | intAck;
      end
    end
  endtask

  // Register read port answers two edges after the index
  task rdq(input [2:0] i, input [15:0] e);
    begin
      rdIdx <= i;
      repeat (3) @(posedge clk);
      chk(rdData, e);
    end
  endtask

  initial begin
    {psel, penable, pwrite, regWe, aluGo, fetchGo, instrDone, rtiGo} = '0;
    {reqGo, reqByte, intReq, paddr, intVec, pwdata, regIdx, rdIdx} = '0;
    {aluOp, intPri, regData, aluA, aluB, reqData, reqKind, reqAddr} = '0;
    nMismatch = 0;
    nTests = 0;
    ce = 1'h1;
    aluWr = 1'h1;
    aluDst = 3'h2;
    reset = 1'h1;
    repeat (4) @(posedge clk);
    reset <= 1'h0;
    apb(8'h00, 1'h0, 32'h0);
    apb(8'h04, 1'h0, 32'h0);
    apb(8'h08, 1'h0, 32'h0);
    apb(8'h20, 1'h0, 32'h0);
    chk(lastErr, 1'h1);
    apb(8'h00, 1'h1, 32'h0000FFFF);
    apb(8'h00, 1'h0, 32'h0000FFEF);
    apb(8'h00, 1'h1, 32'h0);
    wreg(3'h6, 16'h0100);
    wreg(3'h7, 16'h0040);
    apb(8'h04, 1'h0, 32'h0100);
    apb(8'h08, 1'h0, 32'h0040);
    rdq(3'h7, 16'h0040);
    wreg(3'h1, 16'h1357);
    rdq(3'h1, 16'h1357);
    ce <= 1'h0;
    wreg(3'h6, 16'h0BAD);
    ce <= 1'h1;
    apb(8'h04, 1'h0, 32'h0100);
    $display("register test done");
    alu(3'h1, 16'h7FFF, 16'h0001, 4'hA);
    alu(3'h1, 16'hFFFF, 16'h0001, 4'h5);
    alu(3'h4, 16'h0001, 16'h0000, 4'h7);
    alu(3'h3, 16'h8000, 16'h0000, 4'h7);
    alu(3'h5, 16'h8000, 16'h8000, 4'h9);
    alu(3'h2, 16'h8000, 16'h0001, 4'h2);
    alu(3'h0, 16'h0000, 16'h1234, 4'h4);
    alu(3'h6, 16'h00F0, 16'h0F00, 4'h0);
    rdq(3'h2, 16'h0FF0);
    rdq(3'h6, 16'h0100);
    $display("flag test done");
    req(4'h8, 1'h0, 22'h000040, 16'h1234, 16'h0, 1'h0);
    req(4'h8, 1'h1, 22'h000041, 16'h00AB, 16'h0, 1'h0);
    req(4'h1, 1'h0, 22'h000040, 16'h0, 16'hAB34, 1'h0);
    req(4'h2, 1'h0, 22'h000040, 16'h5555, 16'hAB34, 1'h0);
    req(4'h4, 1'h1, 22'h000040, 16'h0077, 16'h5555, 1'h0);
    req(4'h1, 1'h0, 22'h000040, 16'h0, 16'h5577, 1'h0);
    req(4'h1, 1'h0, 22'h000043, 16'h0, 16'h0, 1'h1);
    apb(8'h0C, 1'h0, 32'h2);
    apb(8'h0C, 1'h1, 32'h2);
    apb(8'h0C, 1'h0, 32'h0);
    req(4'h1, 1'h0, 22'h3FFFFE, 16'h0, 16'h02FE, 1'h0);
    $display("bus test done");
    pulse(2'h2);
    waitOn(3'h2);
    chk(instrWord, 16'h5577);
    chk(pc, 16'h0042);
    $display("fetch test done");
    req(4'h8, 1'h0, 22'h000060, 16'h0100, 16'h0, 1'h0);
    req(4'h8, 1'h0, 22'h000062, 16'h0010, 16'h0, 1'h0);
    wreg(3'h6, 16'h0060);
    pulse(2'h1);
    waitOn(3'h3);
    waitOn(3'h5);
    chk(pc, 16'h0100);
    chk({sp, processor_status_word}, 32'h00640010);
    req(4'h8, 1'h0, 22'h000062, 16'h0000, 16'h0, 1'h0);
    wreg(3'h7, 16'h0300);
    pulse(2'h0);
    waitOn(3'h3);
    waitOn(3'h5);
    chk({pc, processor_status_word}, 32'h020C020E);
    chk(sp, 16'h0060);
    req(4'h1, 1'h0, 22'h000062, 16'h0, 16'h0010, 1'h0);
    req(4'h1, 1'h0, 22'h000060, 16'h0, 16'h0300, 1'h0);
    $display("trap test done");
    apb(8'h10, 1'h1, 32'h1);
    intReq <= 1'h1;
    intPri <= 3'h3;
    intVec <= 8'h48;
    pulse(2'h0);
    noAck;
    chk(seen, 1'h0);
    apb(8'h00, 1'h1, 32'h00C0);
    intPri <= 3'h5;
    pulse(2'h0);
    noAck;
    chk(seen, 1'h0);
    intPri <= 3'h7;
    pulse(2'h0);
    waitOn(3'h4);
    intReq <= 1'h0;
    waitOn(3'h5);
    chk({pc, processor_status_word}, 32'h0248024A);
    $display("interrupt test done");
    wrapUp;
  end
endmodule
